// [hw/fault_regs_pkg.sv]
// package: coprocessor encodings, fields and codes for the fault registers
package fault_regs_pkg;

  // ==========================================================
  // coprocessor register selectors
  // ==========================================================
  localparam logic [3:0] CRN_FAULT_STATUS  = 4'h5;
  localparam logic [3:0] CRN_FAULT_ADDRESS = 4'h6;
  localparam logic [3:0] CRM_PRIMARY       = 4'h0;
  localparam logic [3:0] CRM_AUX           = 4'h1;
  localparam logic [2:0] OP1_ZERO          = 3'h0;
  localparam logic [2:0] OP2_DATA          = 3'h0;
  localparam logic [2:0] OP2_INSTR         = 3'h1;
  localparam logic [2:0] OP2_INSTR_ADDR    = 3'h2;

  // ==========================================================
  // status register fields and reset value
  // ==========================================================
  localparam int          QUAL_BIT       = 12;
  localparam int          FS_HIGH_BIT    = 10;
  localparam logic [31:0] STATUS_MASK    = 32'h0000140F;
  localparam logic [31:0] STATUS_RESET   = 32'h00000000;
  localparam logic [31:0] ADDRESS_RESET  = 32'h00000000;
  localparam logic        QUAL_RESET     = 1'b0;

  // ==========================================================
  // five-bit fault codes (qualifier kept apart)
  // ==========================================================
  localparam logic [4:0] FC_L1_EXT       = 5'h0C;
  localparam logic [4:0] FC_L2_EXT       = 5'h0E;
  localparam logic [4:0] FC_TRANS_SECT   = 5'h05;
  localparam logic [4:0] FC_TRANS_PAGE   = 5'h07;
  localparam logic [4:0] FC_ACC_SECT     = 5'h03;
  localparam logic [4:0] FC_ACC_PAGE     = 5'h06;
  localparam logic [4:0] FC_DOM_SECT     = 5'h09;
  localparam logic [4:0] FC_DOM_PAGE     = 5'h0B;
  localparam logic [4:0] FC_PERM_SECT    = 5'h0D;
  localparam logic [4:0] FC_PERM_PAGE    = 5'h0F;
  localparam logic [4:0] FC_SYNC_EXT     = 5'h08;
  localparam logic [4:0] FC_DEBUG        = 5'h02;

  // fault request vector positions, highest priority first
  localparam int NUM_FAULTS   = 12;
  localparam int FR_L1_EXT     = 0;
  localparam int FR_L2_EXT     = 1;
  localparam int FR_TRANS_SECT = 2;
  localparam int FR_TRANS_PAGE = 3;
  localparam int FR_ACC_SECT   = 4;
  localparam int FR_ACC_PAGE   = 5;
  localparam int FR_DOM_SECT   = 6;
  localparam int FR_DOM_PAGE   = 7;
  localparam int FR_PERM_SECT  = 8;
  localparam int FR_PERM_PAGE  = 9;
  localparam int FR_SYNC_EXT   = 10;
  localparam int FR_DEBUG      = 11;

  // ==========================================================
  // access outcome of a coprocessor request
  // ==========================================================
  typedef enum logic [1:0] {
    ACC_IDLE  = 2'b00,
    ACC_DONE  = 2'b01,
    ACC_UNDEF = 2'b10
  } access_e;

endpackage : fault_regs_pkg

// [hw/fault_code_encoder.sv]
// priority encoder from simultaneous fault requests to one fault code
`timescale 1ns/1ps

module fault_code_encoder (
  input  wire logic [fault_regs_pkg::NUM_FAULTS-1:0] faultReq,
  output logic                                       anyFault,
  output logic [4:0]                                 faultCode,
  output logic                                       isExternal
);
  import fault_regs_pkg::*;

  // code table indexed by request position
  function automatic logic [4:0] code_of(input int idx);
    case (idx)
      FR_L1_EXT:     code_of = FC_L1_EXT;      // [RULE_05]
      FR_L2_EXT:     code_of = FC_L2_EXT;      // [RULE_05]
      FR_TRANS_SECT: code_of = FC_TRANS_SECT;  // [RULE_06]
      FR_TRANS_PAGE: code_of = FC_TRANS_PAGE;  // [RULE_06]
      FR_ACC_SECT:   code_of = FC_ACC_SECT;    // [RULE_07]
      FR_ACC_PAGE:   code_of = FC_ACC_PAGE;    // [RULE_07]
      FR_DOM_SECT:   code_of = FC_DOM_SECT;    // [RULE_08]
      FR_DOM_PAGE:   code_of = FC_DOM_PAGE;    // [RULE_08]
      FR_PERM_SECT:  code_of = FC_PERM_SECT;   // [RULE_09]
      FR_PERM_PAGE:  code_of = FC_PERM_PAGE;   // [RULE_09]
      FR_SYNC_EXT:   code_of = FC_SYNC_EXT;    // [RULE_10]
      default:       code_of = FC_DEBUG;       // [RULE_10]
    endcase
  endfunction : code_of

  // lowest index wins; scan from lowest priority upward
  always_comb begin
    anyFault   = |faultReq;
    faultCode  = FC_DEBUG;
    isExternal = 1'b0;
    for (int i = NUM_FAULTS - 1; i >= 0; i--) begin
      if (faultReq[i]) begin
        faultCode  = code_of(i);
        isExternal = (i == FR_L1_EXT) || (i == FR_L2_EXT) ||
                     (i == FR_SYNC_EXT);
      end
    end
  end

endmodule : fault_code_encoder

// [hw/fault_status_address_regs.sv]
// fault status and fault address registers behind coprocessor access
// Function
// [RULE_01] status register keeps source of the latest instruction fault
// [RULE_02] bit 12 qualifier: 0 decode error, 1 slave error
// [RULE_03] bit 11 and bits 9..4 read zero
// [RULE_04] fault code is bit 10 with bits 3..0, qualifier in bit 12
// [RULE_05] level-1 then level-2 translation external abort highest
// [RULE_06] then translation faults, section 000101, page 000111
// [RULE_07] then access flag faults, section 000011, page 000110
// [RULE_08] then domain faults, section 001001, page 001011
// [RULE_09] then permission faults, section 001101, page 001111
// [RULE_10] then sync external abort x01000, debug event 000010 last
// [RULE_11] reserved codes never produced
// [RULE_12] qualifier resets to 0
// [RULE_13] read c5 opcode2 1 returns status register
// [RULE_14] write c5 opcode2 1 loads status; software keeps 31..4 zero
// [RULE_15] external abort to monitor updates secure data status copy
// [RULE_16] auxiliary status registers at c5 c1 read zero, ignore writes
// [RULE_17] auxiliary registers shared, not banked
// [RULE_18] data fault captures address into banked data address reg
// [RULE_19] write to data fault address replaces contents
// [RULE_20] prefetch abort captures address into banked instr address reg
// [RULE_21] write to instruction fault address replaces contents
// [RULE_22] registers reachable only in privileged modes
// [RULE_23] unprivileged access raises undefined, leaves contents
`timescale 1ns/1ps

module fault_status_address_regs (
  input  wire logic                                  clk,
  input  wire logic                                  rst_n,
  // coprocessor request, taken on any cycle with cpReq high
  input  wire logic                                  cpReq,
  input  wire logic                                  cpWrite,
  input  wire logic [2:0]                            cpOpc1,
  input  wire logic [3:0]                            cpCrn,
  input  wire logic [3:0]                            cpCrm,
  input  wire logic [2:0]                            cpOpc2,
  input  wire logic [31:0]                           cpWdata,
  input  wire logic                                  privileged,
  input  wire logic                                  nonSecure,
  output logic                                       cpAck,
  output logic                                       cpUndef,
  output logic                                       cpHit,
  output logic [31:0]                                cpRdata,
  // instruction fault report
  input  wire logic                                  instrFaultValid,
  input  wire logic [fault_regs_pkg::NUM_FAULTS-1:0] instrFaultReq,
  input  wire logic                                  instrFaultSlvErr,
  input  wire logic [31:0]                           instrFaultAddr,
  // data fault report
  input  wire logic                                  dataFaultValid,
  input  wire logic [31:0]                           dataFaultAddr,
  input  wire logic [31:0]                           dataFaultStatus,
  // monitor routing of external aborts
  input  wire logic                                  external_abort_to_monitor,
  input  wire logic                                  monitorExtAbort,
  // data status values for the data fault status register owner, and the current bank's instruction status view
  output logic                                       secureDataStatusWe,
  output logic [31:0]                                secureDataStatus,
  output logic [31:0]                                instrStatusView
);
  import fault_regs_pkg::*;

  // ==========================================================
  // request decode
  // ==========================================================
  logic        anyFault;
  logic [4:0]  faultCode;
  logic        isExternal;
  logic [1:0]  bank;
  logic        selInstrStatus;
  logic        selAux;
  logic        selDataAddr;
  logic        selInstrAddr;
  logic        mapped;
  logic        allowed;
  logic        wrInstrStatus;
  logic        wrDataAddr;
  logic        wrInstrAddr;
  logic [31:0] readMux;

  // match a coprocessor register by its four selectors
  function automatic logic cp_match(input logic [3:0] crn,
                                    input logic [3:0] crm,
                                    input logic [2:0] op2);
    cp_match = (cpOpc1 == OP1_ZERO) && (cpCrn == crn) &&
               (cpCrm == crm) && (cpOpc2 == op2);
  endfunction : cp_match

  // place a five-bit code and qualifier into register layout
  function automatic logic [31:0] pack_status(input logic [4:0] code,
                                              input logic       qual);
    logic [31:0] v;
    v = 32'h00000000;
    v[QUAL_BIT]    = qual;
    v[FS_HIGH_BIT] = code[4];
    v[3:0]         = code[3:0];
    pack_status = v;
  endfunction : pack_status

  // bank index: 0 secure, 1 non-secure
  assign bank = {1'b0, nonSecure};

  // register selects; a process, so any selector change redoes the decode
  always_comb begin
    selInstrStatus = cp_match(CRN_FAULT_STATUS, CRM_PRIMARY, OP2_INSTR);
    selAux = cp_match(CRN_FAULT_STATUS, CRM_AUX, OP2_DATA) ||
             cp_match(CRN_FAULT_STATUS, CRM_AUX, OP2_INSTR);  // [RULE_17]
    selDataAddr  = cp_match(CRN_FAULT_ADDRESS, CRM_PRIMARY, OP2_DATA);
    selInstrAddr = cp_match(CRN_FAULT_ADDRESS, CRM_PRIMARY,
                            OP2_INSTR_ADDR);
  end
  assign mapped  = selInstrStatus | selAux | selDataAddr | selInstrAddr;
  // privileged gate on every access
  assign allowed = cpReq & mapped & privileged;               // [RULE_22]

  // write strobes, none in user mode
  assign wrInstrStatus = allowed & cpWrite & selInstrStatus;   // [RULE_23]
  assign wrDataAddr    = allowed & cpWrite & selDataAddr;      // [RULE_23]
  assign wrInstrAddr   = allowed & cpWrite & selInstrAddr;     // [RULE_23]

  // ==========================================================
  // fault code encoder
  // ==========================================================
  fault_code_encoder u_encoder (
    .faultReq   (instrFaultReq),
    .anyFault   (anyFault),
    .faultCode  (faultCode),
    .isExternal (isExternal)
  );

  // ==========================================================
  // banked instruction fault status and fault address registers
  // ==========================================================
  logic [31:0] instrStatus_q [2];
  logic [31:0] dataAddr_q    [2];
  logic [31:0] instrAddr_q   [2];

  genvar b;
  generate
    for (b = 0; b < 2; b++) begin : g_bank
      logic hereWr;
      logic hereFault;
      assign hereWr    = (bank == 2'(b));
      assign hereFault = (bank == 2'(b));

      // status: software write loads it, a fault overrides it
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          instrStatus_q[b] <= STATUS_RESET;                    // [RULE_12]
        end else if (instrFaultValid && anyFault && hereFault) begin
          // prioritised code, qualifier only on external aborts
          instrStatus_q[b] <= pack_status(faultCode,
                              isExternal & instrFaultSlvErr);  // [RULE_01] [RULE_02] [RULE_04] [RULE_11]
        end else if (wrInstrStatus && hereWr) begin
          // unimplemented bits are never stored
          instrStatus_q[b] <= cpWdata & STATUS_MASK;           // [RULE_14] [RULE_03]
        end
      end

      // data fault address: capture beats software write
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          dataAddr_q[b] <= ADDRESS_RESET;
        end else if (dataFaultValid && hereFault) begin
          dataAddr_q[b] <= dataFaultAddr;                      // [RULE_18]
        end else if (wrDataAddr && hereWr) begin
          dataAddr_q[b] <= cpWdata;                            // [RULE_19]
        end
      end

      // instruction fault address on prefetch abort
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          instrAddr_q[b] <= ADDRESS_RESET;
        end else if (instrFaultValid && anyFault && hereFault) begin
          instrAddr_q[b] <= instrFaultAddr;                    // [RULE_20]
        end else if (wrInstrAddr && hereWr) begin
          instrAddr_q[b] <= cpWdata;                           // [RULE_21]
        end
      end
    end
  endgenerate

  // ==========================================================
  // read path
  // ==========================================================
  // read data selection
  always_comb begin
    readMux = 32'h00000000;
    if (selInstrStatus) begin
      readMux = instrStatus_q[nonSecure] & STATUS_MASK;        // [RULE_13] [RULE_03]
    end else if (selAux) begin
      readMux = 32'h00000000;                                  // [RULE_16]
    end else if (selDataAddr) begin
      readMux = dataAddr_q[nonSecure];
    end else if (selInstrAddr) begin
      readMux = instrAddr_q[nonSecure];
    end
  end

  // registered answer one cycle after the request
  access_e result_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= ACC_IDLE;
    end else if (cpReq && !allowed) begin
      result_q <= ACC_UNDEF;                                   // [RULE_23]
    end else if (allowed) begin
      result_q <= ACC_DONE;
    end else begin
      result_q <= ACC_IDLE;
    end
  end

  // read data register, cleared on refused access
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpRdata <= 32'h00000000;
    end else if (allowed && !cpWrite) begin
      cpRdata <= readMux;
    end else if (cpReq) begin
      cpRdata <= 32'h00000000;
    end
  end

  // handshake decode
  always_comb begin
    case (result_q)
      ACC_DONE: begin
        cpAck   = 1'b1;
        cpUndef = 1'b0;
      end
      ACC_UNDEF: begin
        cpAck   = 1'b1;
        cpUndef = 1'b1;
      end
      default: begin
        cpAck   = 1'b0;
        cpUndef = 1'b0;
      end
    endcase
  end
  assign cpHit = mapped;

  // ==========================================================
  // monitor routing of external aborts
  // ==========================================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      secureDataStatusWe <= 1'b0;
      secureDataStatus   <= STATUS_RESET;
    end else begin
      secureDataStatusWe <= external_abort_to_monitor &
                            monitorExtAbort;                   // [RULE_15]
      if (external_abort_to_monitor && monitorExtAbort) begin
        secureDataStatus <= dataFaultStatus;                   // [RULE_15]
      end
    end
  end

  // current bank's status for observers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      instrStatusView <= STATUS_RESET;
    end else begin
      instrStatusView <= instrStatus_q[nonSecure] & STATUS_MASK;
    end
  end

endmodule : fault_status_address_regs

// [sim/fault_status_address_regs_sva.sv]
// checker: port-level properties of the fault register block
`timescale 1ns/1ps

module fault_status_address_regs_sva
  import fault_regs_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        cpReq,
  input wire logic        cpWrite,
  input wire logic [2:0]  cpOpc1,
  input wire logic [3:0]  cpCrn,
  input wire logic [3:0]  cpCrm,
  input wire logic [2:0]  cpOpc2,
  input wire logic        privileged,
  input wire logic        cpAck,
  input wire logic        cpUndef,
  input wire logic        cpHit,
  input wire logic [31:0] cpRdata,
  input wire logic [31:0] dataFaultStatus,
  input wire logic        external_abort_to_monitor,
  input wire logic        monitorExtAbort,
  input wire logic        secureDataStatusWe,
  input wire logic [31:0] secureDataStatus
);
  // ==========================================================
  // selector decode helpers
  // ==========================================================
  wire logic sel5 = cpOpc1 == OP1_ZERO && cpCrn == CRN_FAULT_STATUS;
  wire logic selStat = sel5 && cpCrm == CRM_PRIMARY && cpOpc2 == OP2_INSTR;
  wire logic selAux = sel5 && cpCrm == CRM_AUX && cpOpc2[2:1] == 2'b00;
  wire logic statRead = cpReq && selStat && !cpWrite;
  wire logic monAbort = external_abort_to_monitor && monitorExtAbort;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // access answer
  // ==========================================================
  property p_ack; cpAck == $past(cpReq); endproperty
  a_ack: assert property (p_ack)
    else $error("ack not one cycle after request");
  property p_unpriv; cpReq && !privileged |=> cpUndef && cpRdata == 0;
  endproperty
  a_unpriv: assert property (p_unpriv)
    else $error("unprivileged access not refused");
  property p_undefAck; cpUndef |-> cpAck; endproperty
  a_undefAck: assert property (p_undefAck)
    else $error("undefined answer without ack");
  property p_hit; cpReq && privileged |=> cpUndef == !$past(cpHit);
  endproperty
  a_hit: assert property (p_hit)
    else $error("undefined answer does not follow register decode");
  property p_statOk; cpReq && privileged && selStat |=> !cpUndef; endproperty
  a_statOk: assert property (p_statOk)
    else $error("status register access refused");
  property p_aux;
    cpReq && privileged && !cpWrite && selAux |=> !cpUndef && cpRdata == 0;
  endproperty
  a_aux: assert property (p_aux)
    else $error("auxiliary status read not zero");
  property p_resv;
    cpAck && !cpUndef && $past(statRead) |-> (cpRdata & ~STATUS_MASK) == 0;
  endproperty
  a_resv: assert property (p_resv)
    else $error("reserved status bits not zero");

  // ==========================================================
  // secure data status forwarding
  // ==========================================================
  property p_secCopy;
    monAbort |=> secureDataStatusWe && secureDataStatus == $past(dataFaultStatus);
  endproperty
  a_secCopy: assert property (p_secCopy)
    else $error("secure data status not forwarded");
  property p_secCause; secureDataStatusWe |-> $past(monAbort); endproperty
  a_secCause: assert property (p_secCause)
    else $error("secure data status written without cause");

endmodule : fault_status_address_regs_sva

// [sim/tb.sv]
// testbench: coprocessor access and fault capture of the fault registers
`timescale 1ns/1ps

module tb;
  import fault_regs_pkg::*;
  logic        clk, rst_n, cpReq, cpWrite, privileged, nonSecure;
  logic [2:0]  cpOpc1, cpOpc2, o1;
  logic [3:0]  cpCrn, cpCrm;
  logic [31:0] cpWdata, cpRdata, instrFaultAddr, dataFaultAddr;
  logic        cpAck, cpUndef, cpHit, instrFaultValid, instrFaultSlvErr;
  logic [11:0] instrFaultReq, req;
  logic        dataFaultValid, external_abort_to_monitor, monitorExtAbort;
  logic [31:0] dataFaultStatus, secureDataStatus, instrStatusView, a;
  logic        secureDataStatusWe, pv, ns, q;
  logic [31:0] mStat [2], mIfar [2], mDfar [2];
  logic [33:0] expQ [$];
  logic [33:0] e;
  int          seed, numErrors, nCompared, cyc;
  localparam logic [10:0] S_STAT = {CRN_FAULT_STATUS, CRM_PRIMARY, OP2_INSTR};
  localparam logic [10:0] S_DATA_FAULT_ADDRESS = {CRN_FAULT_ADDRESS, CRM_PRIMARY, OP2_DATA};
  localparam logic [10:0] S_INSTR_FAULT_ADDRESS = {CRN_FAULT_ADDRESS, CRM_PRIMARY,
                                    OP2_INSTR_ADDR};
  localparam logic [10:0] SELS [5] = '{S_STAT, S_DATA_FAULT_ADDRESS, S_INSTR_FAULT_ADDRESS,
    {CRN_FAULT_STATUS, CRM_AUX, OP2_DATA}, {CRN_FAULT_STATUS, CRM_AUX, OP2_INSTR}};
  localparam logic [4:0] CODES [12] = '{FC_L1_EXT, FC_L2_EXT, FC_TRANS_SECT,
    FC_TRANS_PAGE, FC_ACC_SECT, FC_ACC_PAGE, FC_DOM_SECT, FC_DOM_PAGE,
    FC_PERM_SECT, FC_PERM_PAGE, FC_SYNC_EXT, FC_DEBUG};

  fault_status_address_regs DUT (.*);

  // clock and cycle ceiling
  initial clk = 1'b0;
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      numErrors++;
      stopTest();
    end
  end

  // ==========================================================
  // helpers
  // ==========================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      numErrors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [31:0] mdl(input logic [10:0] sel);
    case (sel)
      S_STAT:  return mStat[ns];
      S_DATA_FAULT_ADDRESS:  return mDfar[ns];
      S_INSTR_FAULT_ADDRESS:  return mIfar[ns];
      default: return 32'h0;
    endcase
  endfunction : mdl

  // one access per cycle, expectation noted for the watcher
  task automatic acc(input logic w, input logic [10:0] sel,
                     input logic [31:0] d, input logic u);
    @(negedge clk);
    {cpReq, cpWrite, cpCrn, cpCrm, cpOpc2, cpWdata} = {1'b1, w, sel, d};
    cpOpc1 = o1;
    privileged = pv;
    nonSecure = ns;
    expQ.push_back({!w || u, u, (w || u) ? 32'h0 : mdl(sel)});
    if (w && !u) begin
      case (sel)
        S_STAT:  mStat[ns] = d & STATUS_MASK;
        S_DATA_FAULT_ADDRESS:  mDfar[ns] = d;
        S_INSTR_FAULT_ADDRESS:  mIfar[ns] = d;
        default: ;
      endcase
    end
  endtask : acc

  // one-cycle fault report pulse
  task automatic flt(input logic iv, input logic dv, input logic [11:0] r,
                     input logic s, input logic [31:0] ad);
    @(negedge clk);
    cpReq = 1'b0;
    nonSecure = ns;
    {instrFaultValid, instrFaultReq, instrFaultSlvErr} = {iv, r, s};
    {instrFaultAddr, dataFaultValid, dataFaultAddr} = {ad, dv, ad};
    @(negedge clk);
    {instrFaultValid, dataFaultValid} = 2'b00;
  endtask : flt

  task automatic stopTest();
    $display("compared %0d errors %0d", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stopTest

  // watcher: oldest expectation against each settled answer
  always @(negedge clk) begin
    if (rst_n && cpAck === 1'b1) begin
      e = expQ.size() > 0 ? expQ.pop_front() : 34'h3FFFFFFFF;
      check({31'h0, cpUndef}, {31'h0, e[32]});
      if (e[33]) check(cpRdata, e[31:0]);
    end
  end

  // ==========================================================
  // main sequence
  // ==========================================================
  initial begin
    seed = 32'h8139;
    {rst_n, cpReq, cpWrite, cpOpc1, cpCrn, cpCrm, cpOpc2, cpWdata} = '0;
    {privileged, nonSecure, instrFaultValid, instrFaultReq} = '0;
    {instrFaultSlvErr, instrFaultAddr, dataFaultValid, dataFaultAddr} = '0;
    {dataFaultStatus, external_abort_to_monitor, monitorExtAbort} = '0;
    {pv, o1, ns, numErrors, nCompared, cyc} = {1'b1, 3'h0, 1'b0, 96'h0};
    mStat = '{2{32'h0}};
    mIfar = '{2{32'h0}};
    mDfar = '{2{32'h0}};
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    // reset values, then random writes and read-back per bank
    for (int b = 0; b < 8; b++) begin
      ns = b[0];
      foreach (SELS[k]) acc(b[2] ^ b[1], SELS[k], $random(seed), 1'b0);
    end
    // refused: unprivileged, unmapped, wrong first opcode
    pv = 1'b0;
    foreach (SELS[k]) acc(1'b1, SELS[k], $random(seed), 1'b1);
    foreach (SELS[k]) acc(1'b0, SELS[k], 32'h0, 1'b1);
    pv = 1'b1;
    acc(1'b1, {CRN_FAULT_ADDRESS, CRM_PRIMARY, 3'h1}, 32'hFFFFFFFF, 1'b1);
    o1 = 3'h1;
    acc(1'b1, S_STAT, 32'hFFFFFFFF, 1'b1);
    o1 = 3'h0;
    foreach (SELS[k]) acc(1'b0, SELS[k], 32'h0, 1'b0);
    // each fault code wins over every lower one raised with it
    for (int i = 0; i < 12; i++) begin
      req = 12'($random(seed)) & ~((12'h1 << i) - 12'h1) | (12'h1 << i);
      {q, a, ns} = {1'($random(seed)), 32'($random(seed)), 1'(i)};
      flt(1'b1, 1'b0, req, q, a);
      q = q && (i == 0 || i == 1 || i == 10);
      mStat[ns] = {19'h0, q, 1'b0, CODES[i][4], 6'h0, CODES[i][3:0]};
      mIfar[ns] = a;
      acc(1'b0, S_STAT, 32'h0, 1'b0);
      check(instrStatusView, mStat[ns]);
      acc(1'b0, S_INSTR_FAULT_ADDRESS, 32'h0, 1'b0);
      ns = ~ns;
      acc(1'b0, S_STAT, 32'h0, 1'b0);
    end
    // data fault address capture per bank
    for (int i = 0; i < 4; i++) begin
      {ns, a} = {1'(i), 32'($random(seed))};
      flt(1'b0, 1'b1, 12'h0, 1'b0, a);
      mDfar[ns] = a;
      acc(1'b0, S_DATA_FAULT_ADDRESS, 32'h0, 1'b0);
    end
    // external aborts routed to the monitor
    repeat (12) begin
      @(negedge clk);
      cpReq = 1'b0;
      dataFaultStatus = $random(seed);
      {external_abort_to_monitor, monitorExtAbort} = 2'($random(seed));
    end
    repeat (4) @(negedge clk);
    check(32'(expQ.size()), 32'h0);
    stopTest();
  end
endmodule : tb

bind fault_status_address_regs fault_status_address_regs_sva u_sva (.*);
